// [verilog/ibm_pkg.sv]
// Constants and types for the interface bridge block modifier register bank.
// Assumes a plain register port with 12-bit byte addresses and 32-bit data.
// How it works
// (R1) Bypass merge is one read/write bit at 0x024, reset 0, present only with upsizing or downsizing.
// (R2) Long burst control is one read/write bit at 0x02c, present only when downsizing onto AXI4.
// (R3) Long burst control 0 makes the bridge break long bursts; 1 lets long bursts out.
// (R4) Without software register access the long burst control holds its default of 0.
// (R5) Write FIFO threshold is four read/write bits at 0x040, effective only with a non-zero configured threshold.
// (R6) Write FIFO threshold reset value is the configured threshold, not a fixed constant.
// (R7) AHB master control is two read/write bits at 0x044, reset 0, AHB only: bit 0 decode error, bit 1 force incr.
// (R8) Issuing override at 0x108 exists only with upsizing, downsizing or a FIFO on any channel.
// (R9) A set issuing override bit limits outstanding transactions in that direction to one; reset 0.
// (R10) Issuing override bit 0 is the read direction and bit 1 the write direction.
// (R11) Clock-boundary selector codes: 0 1:1, 1 m:1, 2 1:n, 3 m:n, 4 async, reset 4, 5 to 7 reserved.
// (R12) Reserved offsets read as zero and ignore writes.
package ibm_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFS_BYPASS_MERGE = 12'h024;
    localparam logic [11:0] OFS_LONG_BURST = 12'h02c;
    localparam logic [11:0] OFS_WR_FIFO_THR = 12'h040;
    localparam logic [11:0] OFS_AHB_CTRL = 12'h044;
    localparam logic [11:0] OFS_ISSUE_OVR = 12'h108;
    localparam int THR_W = 4;
    localparam logic RST_BYPASS_MERGE = 1'h0;
    localparam logic RST_LONG_BURST = 1'h0;
    localparam logic [1:0] RST_AHB_CTRL = 2'h0;
    localparam logic [1:0] RST_ISSUE_OVR = 2'h0;
    localparam logic [3:0] RST_WR_FIFO_THR_DEF = 4'h0;
    localparam int BIT_DECERR_EN = 0;
    localparam int BIT_FORCE_INCR = 1;
    localparam int BIT_READ_ISS = 0;
    localparam int BIT_WRITE_ISS = 1;
    typedef enum logic [2:0] {
        IBM_SYNC_1_1 = 3'h0,
        IBM_SYNC_M_1 = 3'h1,
        IBM_SYNC_1_N = 3'h2,
        IBM_SYNC_M_N = 3'h3,
        IBM_ASYNC = 3'h4
    } ibm_sync_e;
    localparam logic [2:0] RST_SYNC_MODE = 3'h4;
endpackage : ibm_pkg

// [verilog/ibm_sync_decode.sv]
// Decodes the clock-boundary scheme selector into one-hot scheme flags.
// Assumes the selector is a static setting on the same clock.
module ibm_sync_decode
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_sel,
    output logic [4:0] o_scheme,
    output logic o_reserved
);
    typedef struct packed
    {
        logic [4:0] scheme;
        logic reserved;
    } ibm_dec_s;

    ibm_dec_s st;
    ibm_dec_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.scheme = 5'h00;
        next_st.reserved = 1'b0;
        if (i_sel <= ibm_pkg::RST_SYNC_MODE) // R11
        begin
            next_st.scheme[i_sel] = 1'b1;
        end
        else
        begin
            next_st.reserved = 1'b1; // R11
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st <= '{scheme: 5'h10, reserved: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_scheme = st.scheme;
    assign o_reserved = st.reserved;
endmodule : ibm_sync_decode

// [verilog/ibm_regs.sv]
// Modifier register bank for one interface bridge block.
// Assumes a single-clock register port; read data follow one cycle after the read strobe.
//
// Our own choice: the strobed register port.
module ibm_regs
#(
    parameter bit HAS_RESIZE = 1'b1,
    parameter bit HAS_AXI4_DOWNSIZE = 1'b1,
    parameter bit HAS_PROG_VIEW = 1'b1,
    parameter bit HAS_WR_FIFO = 1'b1,
    parameter bit HAS_ANY_FIFO = 1'b1,
    parameter bit IS_AHB = 1'b1,
    parameter logic [3:0] CFG_WR_FIFO_THR = ibm_pkg::RST_WR_FIFO_THR_DEF,
    parameter logic [2:0] CFG_SYNC_MODE = ibm_pkg::RST_SYNC_MODE
)
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_bypass_merge,
    output logic o_long_burst_en,
    output logic o_break_long_burst,
    output logic [3:0] o_write_fifo_threshold,
    output logic o_wr_fifo_thr_valid,
    output logic o_decerr_en,
    output logic o_force_incr,
    output logic o_read_iss_limit_one,
    output logic o_write_iss_limit_one,
    output logic [4:0] o_sync_scheme,
    output logic o_sync_reserved
);
    localparam bit LB_PRESENT = HAS_AXI4_DOWNSIZE && HAS_PROG_VIEW;
    localparam bit THR_PRESENT = HAS_WR_FIFO && (CFG_WR_FIFO_THR != 4'h0);
    localparam bit ISS_PRESENT = HAS_RESIZE || HAS_ANY_FIFO;

    typedef struct packed
    {
        logic bypass_merge;
        logic long_burst;
        logic [3:0] thr;
        logic [1:0] ahb;
        logic [1:0] iss;
        logic [31:0] rdata;
        logic brk;
        logic thr_valid;
    } ibm_regs_s;

    ibm_regs_s st;
    ibm_regs_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.rdata = 32'h0000_0000; // R12
        if (i_wr)
        begin
            unique case (i_addr)
                ibm_pkg::OFS_BYPASS_MERGE:
                begin
                    if (HAS_RESIZE)
                    begin
                        next_st.bypass_merge = i_wdata[0]; // R1
                    end
                end
                ibm_pkg::OFS_LONG_BURST:
                begin
                    if (LB_PRESENT)
                    begin
                        next_st.long_burst = i_wdata[0]; // R2
                    end
                end
                ibm_pkg::OFS_WR_FIFO_THR:
                begin
                    if (HAS_WR_FIFO)
                    begin
                        next_st.thr = i_wdata[3:0]; // R5
                    end
                end
                ibm_pkg::OFS_AHB_CTRL:
                begin
                    if (IS_AHB)
                    begin
                        next_st.ahb = i_wdata[1:0]; // R7
                    end
                end
                ibm_pkg::OFS_ISSUE_OVR:
                begin
                    if (ISS_PRESENT)
                    begin
                        next_st.iss = i_wdata[1:0]; // R8
                    end
                end
                default:
                begin
                    next_st.iss = st.iss; // R12
                end
            endcase
        end
        if (i_rd)
        begin
            unique case (i_addr)
                ibm_pkg::OFS_BYPASS_MERGE:
                begin
                    next_st.rdata = {31'h0, st.bypass_merge & HAS_RESIZE};
                end
                ibm_pkg::OFS_LONG_BURST:
                begin
                    next_st.rdata = {31'h0, st.long_burst & LB_PRESENT};
                end
                ibm_pkg::OFS_WR_FIFO_THR:
                begin
                    next_st.rdata = HAS_WR_FIFO ? {28'h0, st.thr} : 32'h0;
                end
                ibm_pkg::OFS_AHB_CTRL:
                begin
                    next_st.rdata = IS_AHB ? {30'h0, st.ahb} : 32'h0;
                end
                ibm_pkg::OFS_ISSUE_OVR:
                begin
                    next_st.rdata = ISS_PRESENT ? {30'h0, st.iss} : 32'h0;
                end
                default:
                begin
                    next_st.rdata = 32'h0000_0000; // R12
                end
            endcase
        end
        // Absent long-burst register keeps its default, so bursts always break
        if (!LB_PRESENT)
        begin
            next_st.long_burst = ibm_pkg::RST_LONG_BURST; // R4
        end
        // Absent registers sit at reset so each output is a bare flop, no gating behind it
        if (!HAS_RESIZE)
        begin
            next_st.bypass_merge = ibm_pkg::RST_BYPASS_MERGE; // R1
        end
        if (!IS_AHB)
        begin
            next_st.ahb = ibm_pkg::RST_AHB_CTRL; // R7
        end
        if (!ISS_PRESENT)
        begin
            next_st.iss = ibm_pkg::RST_ISSUE_OVR; // R8
        end
        next_st.brk = !next_st.long_burst; // R3
        next_st.thr_valid = THR_PRESENT; // R5
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st.bypass_merge <= ibm_pkg::RST_BYPASS_MERGE;
            st.long_burst <= ibm_pkg::RST_LONG_BURST;
            st.thr <= CFG_WR_FIFO_THR; // R6
            st.ahb <= ibm_pkg::RST_AHB_CTRL;
            st.iss <= ibm_pkg::RST_ISSUE_OVR; // R9
            st.rdata <= 32'h0000_0000;
            st.brk <= !ibm_pkg::RST_LONG_BURST;
            st.thr_valid <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    ibm_sync_decode u_sync
    (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_sel(CFG_SYNC_MODE),
        .o_scheme(o_sync_scheme),
        .o_reserved(o_sync_reserved)
    );

    assign o_rdata = st.rdata;
    assign o_bypass_merge = st.bypass_merge; // R1
    assign o_long_burst_en = st.long_burst; // R3
    assign o_break_long_burst = st.brk; // R3
    assign o_write_fifo_threshold = st.thr;
    assign o_wr_fifo_thr_valid = st.thr_valid;
    assign o_decerr_en = st.ahb[ibm_pkg::BIT_DECERR_EN]; // R7
    assign o_force_incr = st.ahb[ibm_pkg::BIT_FORCE_INCR]; // R7
    assign o_read_iss_limit_one = st.iss[ibm_pkg::BIT_READ_ISS]; // R10
    assign o_write_iss_limit_one = st.iss[ibm_pkg::BIT_WRITE_ISS]; // R10

    // Protocol checks
    property p_wr_bypass;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_wr && i_addr == ibm_pkg::OFS_BYPASS_MERGE && HAS_RESIZE)
            |=> (o_bypass_merge == $past(i_wdata[0]));
    endproperty
    a_wr_bypass: assert property (p_wr_bypass) else $error("bypass merge not written"); // R1

    property p_wr_long_burst;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_wr && i_addr == ibm_pkg::OFS_LONG_BURST && LB_PRESENT)
            |=> (o_long_burst_en == $past(i_wdata[0]));
    endproperty
    a_wr_long_burst: assert property (p_wr_long_burst) else $error("long burst not written"); // R2

    property p_break;
        @(posedge i_clk) disable iff (!i_resetn)
        o_break_long_burst == !o_long_burst_en;
    endproperty
    a_break: assert property (p_break) else $error("burst break mismatch"); // R3

    property p_no_pv;
        @(posedge i_clk) disable iff (!i_resetn)
        !LB_PRESENT |-> !o_long_burst_en;
    endproperty
    a_no_pv: assert property (p_no_pv) else $error("long burst without register"); // R4

    property p_thr_rd;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_rd && i_addr == ibm_pkg::OFS_WR_FIFO_THR && HAS_WR_FIFO)
            |=> (o_rdata == {28'h0, $past(o_write_fifo_threshold)});
    endproperty
    a_thr_rd: assert property (p_thr_rd) else $error("threshold readback wrong"); // R5

    property p_ahb;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_wr && i_addr == ibm_pkg::OFS_AHB_CTRL && IS_AHB)
            |=> ({o_force_incr, o_decerr_en} == $past(i_wdata[1:0]));
    endproperty
    a_ahb: assert property (p_ahb) else $error("ahb control not written"); // R7

    property p_iss;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_wr && i_addr == ibm_pkg::OFS_ISSUE_OVR && ISS_PRESENT)
            |=> ({o_write_iss_limit_one, o_read_iss_limit_one} == $past(i_wdata[1:0]));
    endproperty
    a_iss: assert property (p_iss) else $error("issue override not written"); // R10

    property p_rsvd;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_rd && i_addr == 12'h028) |=> (o_rdata == 32'h0);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read not zero"); // R12

    property p_rd_once;
        @(posedge i_clk) disable iff (!i_resetn)
        !i_rd |=> (o_rdata == 32'h0);
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("read data stands too long"); // R12

    property p_wr_thr;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_wr && i_addr == ibm_pkg::OFS_WR_FIFO_THR && HAS_WR_FIFO)
            |=> (o_write_fifo_threshold == $past(i_wdata[3:0]));
    endproperty
    a_wr_thr: assert property (p_wr_thr) else $error("threshold not written"); // R5

    property p_thr_valid;
        @(posedge i_clk) disable iff (!i_resetn)
        $past(i_resetn) |-> (o_wr_fifo_thr_valid == THR_PRESENT);
    endproperty
    a_thr_valid: assert property (p_thr_valid) else $error("threshold flag wrong"); // R5

    property p_byp_off;
        @(posedge i_clk) disable iff (!i_resetn)
        !HAS_RESIZE |-> !o_bypass_merge;
    endproperty
    a_byp_off: assert property (p_byp_off) else $error("stray bypass"); // R1

    property p_ahb_off;
        @(posedge i_clk) disable iff (!i_resetn)
        !IS_AHB |-> !(o_decerr_en || o_force_incr);
    endproperty
    a_ahb_off: assert property (p_ahb_off) else $error("stray ahb control"); // R7

    property p_iss_off;
        @(posedge i_clk) disable iff (!i_resetn)
        !ISS_PRESENT |-> !(o_read_iss_limit_one || o_write_iss_limit_one);
    endproperty
    a_iss_off: assert property (p_iss_off) else $error("stray issue override"); // R8

    property p_byp_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        !(i_wr && i_addr == ibm_pkg::OFS_BYPASS_MERGE) |=> $stable(o_bypass_merge);
    endproperty
    a_byp_hold: assert property (p_byp_hold) else $error("bypass merge moved"); // R1

    property p_lb_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        !(i_wr && i_addr == ibm_pkg::OFS_LONG_BURST) |=> $stable(o_long_burst_en);
    endproperty
    a_lb_hold: assert property (p_lb_hold) else $error("long burst moved"); // R2

    property p_thr_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        !(i_wr && i_addr == ibm_pkg::OFS_WR_FIFO_THR) |=> $stable(o_write_fifo_threshold);
    endproperty
    a_thr_hold: assert property (p_thr_hold) else $error("threshold moved"); // R5

    property p_ahb_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        !(i_wr && i_addr == ibm_pkg::OFS_AHB_CTRL) |=> $stable({o_force_incr, o_decerr_en});
    endproperty
    a_ahb_hold: assert property (p_ahb_hold) else $error("ahb control moved"); // R7

    property p_iss_hold;
        @(posedge i_clk) disable iff (!i_resetn)
        !(i_wr && i_addr == ibm_pkg::OFS_ISSUE_OVR)
            |=> $stable({o_write_iss_limit_one, o_read_iss_limit_one});
    endproperty
    a_iss_hold: assert property (p_iss_hold) else $error("issue override moved"); // R9

    property p_rd_byp;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_rd && i_addr == ibm_pkg::OFS_BYPASS_MERGE)
            |=> (o_rdata == {31'h0, $past(o_bypass_merge)});
    endproperty
    a_rd_byp: assert property (p_rd_byp) else $error("bypass readback wrong"); // R1

    property p_rd_lb;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_rd && i_addr == ibm_pkg::OFS_LONG_BURST)
            |=> (o_rdata == {31'h0, $past(o_long_burst_en)});
    endproperty
    a_rd_lb: assert property (p_rd_lb) else $error("long burst readback wrong"); // R2

    property p_rd_ahb;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_rd && i_addr == ibm_pkg::OFS_AHB_CTRL)
            |=> (o_rdata == {30'h0, $past(o_force_incr), $past(o_decerr_en)});
    endproperty
    a_rd_ahb: assert property (p_rd_ahb) else $error("ahb readback wrong"); // R7

    property p_rd_iss;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_rd && i_addr == ibm_pkg::OFS_ISSUE_OVR)
            |=> (o_rdata == {30'h0, $past(o_write_iss_limit_one), $past(o_read_iss_limit_one)});
    endproperty
    a_rd_iss: assert property (p_rd_iss) else $error("issue override readback wrong"); // R10

    c_iss_both: cover property (@(posedge i_clk) o_read_iss_limit_one && o_write_iss_limit_one);
    c_long: cover property (@(posedge i_clk) o_long_burst_en);
    c_ahb: cover property (@(posedge i_clk) o_decerr_en && o_force_incr);
    c_wr_rd: cover property (@(posedge i_clk) i_wr ##1 i_rd);
    c_rsvd_scheme: cover property (@(posedge i_clk) o_sync_reserved);
endmodule : ibm_regs

// [tb/ibm_regs_tb_top.sv]
// Self-checking bench for the modifier register bank, full and minimal configurations.
// Assumes the bank answers reads one cycle after the strobe and never stalls the master.
module ibm_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] o_rdata, m_rdata;
    logic o_bypass_merge, o_long_burst_en, o_break_long_burst, o_wr_fifo_thr_valid;
    logic o_decerr_en, o_force_incr, o_read_iss_limit_one, o_write_iss_limit_one;
    logic [3:0] o_write_fifo_threshold;
    logic [4:0] o_sync_scheme;
    logic o_sync_reserved;
    logic [6:0] m_out;
    logic m_valid, m_res;
    logic [3:0] m_thr;
    int bad_count = 0;
    int cmp_count = 0;
    // Full build; threshold picked non-zero so reset loading and the valid flag show
    ibm_regs #(.CFG_WR_FIFO_THR(4'h9)) DUT (.i_clk(i_clk),
        .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_bypass_merge(o_bypass_merge), .o_long_burst_en(o_long_burst_en),
        .o_break_long_burst(o_break_long_burst), .o_write_fifo_threshold(o_write_fifo_threshold),
        .o_wr_fifo_thr_valid(o_wr_fifo_thr_valid), .o_decerr_en(o_decerr_en),
        .o_force_incr(o_force_incr), .o_read_iss_limit_one(o_read_iss_limit_one),
        .o_write_iss_limit_one(o_write_iss_limit_one), .o_sync_scheme(o_sync_scheme),
        .o_sync_reserved(o_sync_reserved));
    // Stripped build on the same bus: no resizing, write FIFO only, no long burst register, reserved
    // scheme; threshold stays writable but never effective since it is configured zero
    ibm_regs #(.HAS_RESIZE(1'b0), .HAS_PROG_VIEW(1'b0), .HAS_ANY_FIFO(1'b0),
        .CFG_SYNC_MODE(3'h5)) DUT_min (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(m_rdata),
        .o_bypass_merge(m_out[6]), .o_long_burst_en(m_out[5]), .o_break_long_burst(m_out[4]),
        .o_write_fifo_threshold(m_thr), .o_wr_fifo_thr_valid(m_valid), .o_decerr_en(m_out[3]),
        .o_force_incr(m_out[2]), .o_read_iss_limit_one(m_out[1]),
        .o_write_iss_limit_one(m_out[0]), .o_sync_scheme(), .o_sync_reserved(m_res));
    logic [10:0] outs;
    assign outs = {o_bypass_merge, o_long_burst_en, o_break_long_burst, o_write_fifo_threshold,
        o_decerr_en, o_force_incr, o_read_iss_limit_one, o_write_iss_limit_one};
    initial
    begin
        forever #20 i_clk = ~i_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mexp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", o_rdata, exp);
        chk("min_rdata", m_rdata, mexp);
    endtask : rd
    // Reset values, thresholds loaded from configuration, scheme decode
    task automatic t_reset();
        rd(12'h024, 32'h0, 32'h0);
        rd(12'h02c, 32'h0, 32'h0);
        rd(12'h040, 32'h9, 32'h0);
        rd(12'h044, 32'h0, 32'h0);
        rd(12'h108, 32'h0, 32'h0);
        // Valid flag leaves reset at the first edge after release, so look only after reads
        chk("reset_outs", {21'h0, outs}, {21'h0, 11'b00110010000});
        chk("thr_valid", {31'h0, o_wr_fifo_thr_valid}, 32'h1);
        chk("scheme", {27'h0, o_sync_scheme}, 32'h10);
        chk("min_reserved", {31'h0, m_res, o_sync_reserved}, 32'h2);
        chk("min_valid", {31'h0, m_valid}, 32'h0);
    endtask : t_reset
    // All ones into every register: only field bits stick, absent ones stay put
    task automatic t_ones();
        logic [11:0] ofs[5] = '{12'h024, 12'h02c, 12'h040, 12'h044, 12'h108};
        logic [31:0] msk[5] = '{32'h1, 32'h1, 32'hf, 32'h3, 32'h3};
        logic [31:0] mexp[5] = '{32'h0, 32'h0, 32'hf, 32'h3, 32'h0};
        foreach (ofs[k]) wr(ofs[k], 32'hffffffff);
        chk("ones_outs", {21'h0, outs}, {21'h0, 11'b11011111111});
        chk("min_outs", {25'h0, m_out}, {25'h0, 7'b0011100});
        chk("min_thr", {28'h0, m_thr}, 32'hf);
        foreach (ofs[k]) rd(ofs[k], msk[k], mexp[k]);
    endtask : t_ones
    // Single bits land in the documented positions
    task automatic t_bits();
        wr(12'h108, 32'h1);
        chk("iss_read", {30'h0, o_read_iss_limit_one, o_write_iss_limit_one}, 32'h2);
        wr(12'h108, 32'h2);
        chk("iss_write", {30'h0, o_read_iss_limit_one, o_write_iss_limit_one}, 32'h1);
        wr(12'h044, 32'h2);
        chk("ahb_bits", {30'h0, o_decerr_en, o_force_incr}, 32'h1);
        wr(12'h02c, 32'h0);
        chk("burst_break", {30'h0, o_long_burst_en, o_break_long_burst}, 32'h1);
        wr(12'h040, 32'h0);
        chk("thr_zero", {28'h0, o_write_fifo_threshold}, 32'h0);
    endtask : t_bits
    // Reserved holes: read zero, writes leave every control alone
    task automatic t_reserved();
        logic [11:0] hole[8] = '{12'h028, 12'h030, 12'h03c, 12'h100, 12'h104, 12'h10c,
            12'h10e, 12'hffc};
        logic [10:0] keep;
        keep = outs;
        foreach (hole[k]) wr(hole[k], 32'hffffffff);
        chk("hole_outs", {21'h0, outs}, {21'h0, keep});
        foreach (hole[k]) rd(hole[k], 32'h0, 32'h0);
    endtask : t_reserved
    // Write then read with no gap, read data gone one cycle later
    task automatic t_b2b();
        @(posedge i_clk);
        i_addr <= 12'h040;
        i_wdata <= 32'h5;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("b2b_rdata", o_rdata, 32'h5);
        chk("b2b_min_rdata", m_rdata, 32'h5);
        @(posedge i_clk);
        #1;
        chk("rdata_idle", o_rdata, 32'h0);
    endtask : t_b2b
    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (11) @(posedge i_clk);
        #1;
        chk("reset_scheme", {27'h0, o_sync_scheme}, 32'h10);
        @(posedge i_clk);
        i_resetn <= 1'b1;
        t_reset();
        t_ones();
        t_bits();
        t_reserved();
        t_b2b();
        close_out();
    end
    // Whole run is well under 200 cycles; this only trips on a hang
    initial
    begin
        #(40 * 2000);
        bad_count++;
        close_out();
    end
endmodule : ibm_regs_tb_top
